// [sr_controller.sv]
// Summary of operation
// - 2-Kbyte static array plus a separate block of control registers.
// - array answers both program space and data space cycles.
// - byte or word access takes two clocks; long word takes two such cycles.
// - control registers decode only in supervisor data space.
// - register block sits at one of two bases, picked by module map select.
// - 64-byte register block; unused locations read zero, writes ignored.
// - base bits 15:3 compared with address 23:11; low bits pick the word.
// - base register bit 0 is disable flag, set at reset and on overlap.
// - writing a valid non-overlapping base clears disable flag, enables array.
// - only the first base register write after master reset is accepted.
// - a byte write to one half of base register locks the other half.
// - in test mode the lock override bit defeats base write protection.
// - privilege field selects supervisor-only; user cycles then left alone.
// - in normal operation only bus masters reach the array.
// - no array access while running from standby supply.
// - stop bit gives low-power mode: contents kept, access refused, reset sets.
// - reset sets stop, supervisor-only, clears base, disables the array.
// - sync reset finishes current word; second word of long dropped if in first.
// - during microcode emulation no bus access and registers have no effect.
`timescale 1ns/1ns
module sr_controller #(
   parameter int WORDS = sram_pkg::ARRAY_WORDS
) (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        syncReset,
   input  wire logic        busStrobe,
   input  wire logic [23:0] busAddr,
   input  wire logic [1:0]  transferSize,
   input  wire logic        busWrite,
   input  wire logic [15:0] busWrData,
   input  wire logic        busSupervisor,
   input  wire logic        busProgSpace,
   input  wire logic        moduleMapSelect,
   input  wire logic        standbySupply,
   input  wire logic        emulationMode,
   input  wire logic        testMode,
   output      logic        busClaim,
   output      logic        busAck,
   output      logic [15:0] busRdData
);

   localparam int AW = $clog2(WORDS);

   if (WORDS != sram_pkg::ARRAY_WORDS) begin
      $error("array must be 2 Kbyte to match the 11-bit window");
   end

   typedef struct packed {
      sram_pkg::sr_state_t st;
      logic [AW-1:0]       wordIdx;
      logic                wrHigh;
      logic                wrLow;
      logic                isWrite;
      logic                isReg;
      logic [5:0]          regOff;
      logic [15:0]         wrData;
      logic                stop;
      logic                superOnly;
      logic                lockOverride;
      logic [12:0]         base;
      logic                arrayOff;
      logic                lockHigh;
      logic                lockLow;
      logic                inFirstLong;
      logic                dropSecond;
      logic                ack;
      logic [15:0]         rdData;
   } sr_ctl_t;

   sr_ctl_t     cur;
   sr_ctl_t     next_cur;
   logic [15:0] arrayWord;
   logic [23:0] regBase;
   logic        regHit;
   logic        arrayHit;
   logic        arrayOk;
   logic        byteAcc;
   logic        hiLane;
   logic        loLane;
   logic        overlap;
   logic [12:0] newBase;
   logic [15:0] regRead;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   assign regBase = moduleMapSelect ? sram_pkg::REG_BASE_HIGH : sram_pkg::REG_BASE_LOW;
   assign regHit  = busSupervisor && !busProgSpace && !emulationMode
                    && (busAddr[23:6] == regBase[23:6]);
   // program and data space both allowed; coprocessor has no path here
   assign arrayHit = (busAddr[23:11] == cur.base)
                     && !cur.arrayOff
                     && !cur.stop
                     && !standbySupply
                     && !emulationMode
                     && (busSupervisor || !cur.superOnly);
   assign arrayOk  = arrayHit && !(cur.dropSecond && transferSize == sram_pkg::SIZE_LONG);
   // no claim in the ack cycle, so a strobe still held there is not taken twice
   assign busClaim = busStrobe && cur.st == sram_pkg::SR_IDLE && !cur.ack && (regHit || arrayOk);

   assign byteAcc = transferSize == sram_pkg::SIZE_BYTE;
   assign hiLane  = !byteAcc || !busAddr[0];
   assign loLane  = !byteAcc || busAddr[0];

   // ---------------------------------------------------------------
   // register read and base overlap check
   // ---------------------------------------------------------------
   always_comb begin
      regRead = 16'h0000;
      case (cur.regOff)
         sram_pkg::OFF_CONFIG: begin
            regRead[sram_pkg::CFG_STOP_BIT] = cur.stop;
            regRead[sram_pkg::CFG_PRIV_BIT] = cur.superOnly;
         end
         sram_pkg::OFF_TEST: begin
            regRead[sram_pkg::TST_OVERRIDE_BIT] = cur.lockOverride;
         end
         sram_pkg::OFF_BASE: begin
            regRead[15:sram_pkg::BAR_BASE_LSB]    = cur.base;
            regRead[sram_pkg::BAR_DISABLE_BIT] = cur.arrayOff;
         end
         default: begin
            regRead = 16'h0000;
         end
      endcase
   end

   always_comb begin
      newBase = cur.base;
      if (cur.wrHigh) begin
         newBase[12:5] = cur.wrData[15:8];
      end
      if (cur.wrLow) begin
         newBase[4:0] = cur.wrData[7:3];
      end
   end

   assign overlap = newBase == regBase[23:11];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic unlocked;
      unlocked = 1'b0;
      next_cur = cur;
      next_cur.ack = 1'b0;
      case (cur.st)
         sram_pkg::SR_IDLE: begin
            if (busClaim) begin
               next_cur.st      = sram_pkg::SR_ACCESS;
               next_cur.wordIdx = busAddr[AW:1];
               next_cur.wrHigh  = busWrite && hiLane;
               next_cur.wrLow   = busWrite && loLane;
               next_cur.isWrite = busWrite;
               next_cur.isReg   = regHit;
               next_cur.regOff  = {busAddr[5:1], 1'b0};
               next_cur.wrData  = busWrData;
               if (!regHit && transferSize == sram_pkg::SIZE_LONG) begin
                  next_cur.inFirstLong = !cur.inFirstLong;
               end
               next_cur.dropSecond = 1'b0;
            end
         end
         sram_pkg::SR_ACCESS: begin
            next_cur.st  = sram_pkg::SR_IDLE;
            next_cur.ack = 1'b1;
            next_cur.rdData = cur.isReg ? regRead : arrayWord;
            if (cur.isReg && cur.isWrite) begin
               case (cur.regOff)
                  sram_pkg::OFF_CONFIG: begin
                     if (cur.wrHigh) begin
                        next_cur.stop = cur.wrData[sram_pkg::CFG_STOP_BIT];
                        next_cur.superOnly = cur.wrData[sram_pkg::CFG_PRIV_BIT];
                     end
                  end
                  sram_pkg::OFF_TEST: begin
                     if (cur.wrLow) begin
                        next_cur.lockOverride = cur.wrData[sram_pkg::TST_OVERRIDE_BIT];
                     end
                  end
                  sram_pkg::OFF_BASE: begin
                     unlocked = testMode && cur.lockOverride;
                     if ((cur.wrHigh && (!cur.lockHigh || unlocked))
                         || (cur.wrLow && (!cur.lockLow || unlocked))) begin
                        if (cur.wrHigh && (!cur.lockHigh || unlocked)) begin
                           next_cur.base[12:5] = newBase[12:5];
                        end
                        if (cur.wrLow && (!cur.lockLow || unlocked)) begin
                           next_cur.base[4:0] = newBase[4:0];
                        end
                        next_cur.arrayOff = overlap;
                        next_cur.lockHigh = 1'b1;
                        next_cur.lockLow  = 1'b1;
                     end
                  end
                  default: begin
                     next_cur.stop = cur.stop;
                  end
               endcase
            end
         end
         default: begin
            next_cur.st = sram_pkg::SR_IDLE;
         end
      endcase
      // synchronous master reset: control state returns to reset values,
      // while the access already under way still completes
      if (syncReset) begin
         next_cur.stop         = sram_pkg::RST_STOP;
         next_cur.superOnly    = sram_pkg::RST_SUPER_ONLY;
         next_cur.base         = sram_pkg::RST_BASE;
         next_cur.arrayOff     = sram_pkg::RST_DISABLE;
         next_cur.lockHigh     = 1'b0;
         next_cur.lockLow      = 1'b0;
         next_cur.lockOverride = 1'b0;
         next_cur.dropSecond   = next_cur.inFirstLong;
         next_cur.inFirstLong  = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // storage and state register
   // ---------------------------------------------------------------
   sr_array #(
      .WORDS (WORDS)
   ) u_array (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .wordIndex (cur.wordIdx),
      .writeHigh (cur.st == sram_pkg::SR_ACCESS && !cur.isReg && cur.wrHigh),
      .writeLow  (cur.st == sram_pkg::SR_ACCESS && !cur.isReg && cur.wrLow),
      .writeData (cur.wrData),
      .readWord  (arrayWord)
   );

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cur           <= '0;
         cur.st        <= sram_pkg::SR_IDLE;
         cur.stop      <= sram_pkg::RST_STOP;
         cur.superOnly <= sram_pkg::RST_SUPER_ONLY;
         cur.base      <= sram_pkg::RST_BASE;
         cur.arrayOff  <= sram_pkg::RST_DISABLE;
      end else begin
         cur <= next_cur;
      end
   end

   assign busAck    = cur.ack;
   assign busRdData = cur.rdData;

endmodule

// [sram_pkg.sv]
package sram_pkg;

   // ---------------------------------------------------------------
   // array geometry and register block
   // ---------------------------------------------------------------
   localparam int          ARRAY_BYTES    = 2048;
   localparam int          ARRAY_WORDS    = ARRAY_BYTES / 2;
   localparam int          REG_BLOCK_SIZE = 64;
   localparam logic [23:0] REG_BASE_LOW   = 24'h7FFB00;
   localparam logic [23:0] REG_BASE_HIGH  = 24'hFFFB00;

   // register offsets inside the block
   localparam logic [5:0] OFF_CONFIG = 6'h00;
   localparam logic [5:0] OFF_TEST   = 6'h02;
   localparam logic [5:0] OFF_BASE   = 6'h04;

   // field positions
   localparam int CFG_STOP_BIT     = 15;
   localparam int CFG_PRIV_BIT     = 8;
   localparam int TST_OVERRIDE_BIT = 0;
   localparam int BAR_DISABLE_BIT  = 0;
   localparam int BAR_BASE_LSB     = 3;

   // reset values
   localparam logic        RST_STOP       = 1'b1;
   localparam logic        RST_SUPER_ONLY = 1'b1;
   localparam logic [12:0] RST_BASE       = 13'h0000;
   localparam logic        RST_DISABLE    = 1'b1;

   // transfer size encodings
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   typedef enum logic [1:0] {
      SR_IDLE   = 2'b00,
      SR_ACCESS = 2'b01
   } sr_state_t;

endpackage

// [sr_array.sv]
`timescale 1ns/1ns
module sr_array #(
   parameter int WORDS = sram_pkg::ARRAY_WORDS
) (
   input  wire logic                     sys_clk,
   input  wire logic                     reset_n,
   input  wire logic [$clog2(WORDS)-1:0] wordIndex,
   input  wire logic                     writeHigh,
   input  wire logic                     writeLow,
   input  wire logic [15:0]              writeData,
   output      logic [15:0]              readWord
);

   typedef struct packed {
      logic [WORDS-1:0][15:0] mem;
   } sr_array_t;

   sr_array_t cur;
   sr_array_t next_cur;

   if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0) begin
      $error("array depth must be a power of two");
   end

   assign readWord = cur.mem[wordIndex];

   always_comb begin
      next_cur = cur;
      if (writeHigh) begin
         next_cur.mem[wordIndex][15:8] = writeData[15:8];
      end
      if (writeLow) begin
         next_cur.mem[wordIndex][7:0] = writeData[7:0];
      end
   end

   // array holds its contents through low-power mode
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

endmodule

// [sr_checker.sv]
`timescale 1ns/1ns
module sr_checker (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic        syncReset,
   input wire logic        busStrobe,
   input wire logic [23:0] busAddr,
   input wire logic [1:0]  transferSize,
   input wire logic        busWrite,
   input wire logic [15:0] busWrData,
   input wire logic        busSupervisor,
   input wire logic        busProgSpace,
   input wire logic        moduleMapSelect,
   input wire logic        standbySupply,
   input wire logic        emulationMode,
   input wire logic        testMode,
   input wire logic        busClaim,
   input wire logic        busAck,
   input wire logic [15:0] busRdData
);
   logic [23:0] regBase;
   logic        regHit;
   assign regBase = moduleMapSelect ? sram_pkg::REG_BASE_HIGH : sram_pkg::REG_BASE_LOW;
   assign regHit  = busAddr[23:6] == regBase[23:6];
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   ack_timing_a: assert property (busStrobe && busClaim |=> !busAck ##1 busAck)
      else $error("ack not two clocks after take");
   ack_pulse_a: assert property (busAck |=> !busAck)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (busAck |-> $past(busStrobe && busClaim, 2))
      else $error("ack without a taken cycle");
   rd_hold_a: assert property (!$stable(busRdData) |-> busAck)
      else $error("read data changed outside ack");
   standby_block_a: assert property (standbySupply && busStrobe && !regHit |-> !busClaim)
      else $error("array claimed on standby supply");
   emul_block_a: assert property (emulationMode |-> !busClaim)
      else $error("claim during emulation");
   reg_privilege_a: assert property (busStrobe && regHit && (!busSupervisor || busProgSpace) |-> !busClaim)
      else $error("register claimed outside supervisor data");
   sync_stop_a: assert property (syncReset ##1 (busStrobe && !regHit) |-> !busClaim)
      else $error("array claimed after sync reset");
endmodule

// [sr_bus_master.sv]
`timescale 1ns/1ns
module sr_bus_master (
   input  wire logic        sys_clk,
   input  wire logic        busClaim,
   input  wire logic        busAck,
   input  wire logic [15:0] busRdData,
   output      logic        busStrobe,
   output      logic [23:0] busAddr,
   output      logic [1:0]  transferSize,
   output      logic        busWrite,
   output      logic [15:0] busWrData,
   output      logic        busSupervisor,
   output      logic        busProgSpace
);
   initial begin
      {busStrobe, busWrite, busSupervisor, busProgSpace, transferSize} = '0;
      busAddr = '0;
      busWrData = '0;
   end
   // --------------------------------------------------------
   // one bus cycle, held until ack or one cycle if unclaimed
   // --------------------------------------------------------
   task automatic xfer(input logic [23:0] a, input logic [1:0] sz, input logic wr,
                       input logic [15:0] d, input logic sup, input logic prg,
                       output logic cl, output logic [15:0] rd);
      rd = 'x;
      @(posedge sys_clk);
      busStrobe <= 1'b1;
      busAddr <= a;
      transferSize <= sz;
      busWrite <= wr;
      busWrData <= wr ? d : ~busWrData;
      busSupervisor <= sup;
      busProgSpace <= prg;
      #1;
      cl = busClaim;
      for (int n = 0; n < 8 && cl; n++) begin
         @(posedge sys_clk);
         #1;
         if (busAck === 1'b1) begin
            rd = busRdData;
            break;
         end
      end
      @(posedge sys_clk);
      busStrobe <= 1'b0;
      busAddr <= ~busAddr;
      busWrData <= ~busWrData;
   endtask
endmodule

// [sr_controller_tb_top.sv]
`timescale 1ns/1ns
module sr_controller_tb_top;
   logic        sys_clk, reset_n, syncReset, moduleMapSelect, standbySupply, emulationMode, testMode;
   logic        busClaim, busAck, busStrobe, busWrite, busSupervisor, busProgSpace, cl, b;
   logic [23:0] busAddr, a;
   logic [1:0]  transferSize;
   logic [15:0] busRdData, busWrData, d, rv;
   logic [15:0] mem [0:1023];
   int          n_errors, check_count, cycles, idx;
   localparam logic [23:0] ARR = 24'h100000;
   localparam logic [23:0] RB  = sram_pkg::REG_BASE_LOW;
   localparam logic [23:0] RH  = sram_pkg::REG_BASE_HIGH;
   localparam logic [15:0] BV  = {ARR[23:11], 3'h0};
   sr_controller dut (.sys_clk, .reset_n, .syncReset, .busStrobe, .busAddr, .transferSize, .busWrite,
      .busWrData, .busSupervisor, .busProgSpace, .moduleMapSelect, .standbySupply, .emulationMode,
      .testMode, .busClaim, .busAck, .busRdData);
   sr_bus_master m (.sys_clk, .busClaim, .busAck, .busRdData, .busStrobe, .busAddr, .transferSize,
      .busWrite, .busWrData, .busSupervisor, .busProgSpace);
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic rd(input logic [23:0] ad, input logic sup, input logic prg, input logic ec,
                     input logic [15:0] ed);
      logic [15:0] r;
      m.xfer(ad, sram_pkg::SIZE_WORD, 1'b0, 16'h0000, sup, prg, cl, r);
      chk1("claim", ec, cl);
      if (ec) chk16("read data", ed, r);
   endtask
   task automatic wr(input logic [23:0] ad, input logic [1:0] sz, input logic [15:0] dv, input logic ec);
      logic [15:0] r;
      m.xfer(ad, sz, 1'b1, dv, 1'b1, 1'b0, cl, r);
      chk1("write claim", ec, cl);
   endtask
   initial begin
      {reset_n, syncReset, moduleMapSelect, standbySupply, emulationMode, testMode} = '0;
      n_errors = 0;
      check_count = 0;
      cycles = 0;
      foreach (mem[k]) mem[k] = 16'h0000;
      void'($urandom(94065));
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(RB + sram_pkg::OFF_BASE, 1, 0, 1, 16'h0001);
      rd(RB + sram_pkg::OFF_CONFIG, 1, 0, 1, 16'h8100);
      wr(RB + 24'h10, sram_pkg::SIZE_WORD, 16'hFFFF, 1);
      rd(RB + 24'h10, 1, 0, 1, 16'h0000);
      rd(RB + sram_pkg::OFF_CONFIG, 0, 0, 0, 16'h0000);
      rd(RB + sram_pkg::OFF_CONFIG, 1, 1, 0, 16'h0000);
      wr(RB + sram_pkg::OFF_CONFIG, sram_pkg::SIZE_WORD, 16'h0000, 1);
      rd(24'h000000, 1, 0, 0, 16'h0000);
      wr(RB + sram_pkg::OFF_BASE, sram_pkg::SIZE_WORD, BV, 1);
      rd(RB + sram_pkg::OFF_BASE, 1, 0, 1, BV);
      wr(RB + sram_pkg::OFF_BASE, sram_pkg::SIZE_WORD, 16'h2000, 1);
      rd(RB + sram_pkg::OFF_BASE, 1, 0, 1, BV);
      for (int i = 0; i < 30; i++) begin
         idx = $urandom % 1023;
         d = 16'($urandom);
         a = ARR + 24'(2 * idx);
         b = 1'($urandom % 2);
         if (i % 3 == 0) begin
            wr(a, sram_pkg::SIZE_WORD, d, 1);
            mem[idx] = d;
         end else if (i % 3 == 1) begin
            wr(a + 24'(b), sram_pkg::SIZE_BYTE, d, 1);
            if (b) mem[idx][7:0] = d[7:0];
            else mem[idx][15:8] = d[15:8];
         end else begin
            m.xfer(a, sram_pkg::SIZE_LONG, 1'b1, d, 1'b1, 1'b0, cl, rv);
            m.xfer(a + 24'h2, sram_pkg::SIZE_LONG, 1'b1, ~d, 1'b1, 1'b0, cl, rv);
            mem[idx] = d;
            mem[idx + 1] = ~d;
            m.xfer(a, sram_pkg::SIZE_LONG, 1'b0, 16'h0000, 1'b1, 1'b0, cl, rv);
            chk16("long first word", mem[idx], rv);
            m.xfer(a + 24'h2, sram_pkg::SIZE_LONG, 1'b0, 16'h0000, 1'b1, 1'b0, cl, rv);
            chk16("long second word", mem[idx + 1], rv);
         end
         rd(a, 1'($urandom % 2), 1'($urandom % 2), 1, mem[idx]);
      end
      @(posedge sys_clk) standbySupply <= 1'b1;
      rd(ARR, 1, 0, 0, 16'h0000);
      @(posedge sys_clk) {standbySupply, emulationMode} <= 2'h1;
      rd(ARR, 1, 0, 0, 16'h0000);
      rd(RB + sram_pkg::OFF_BASE, 1, 0, 0, 16'h0000);
      @(posedge sys_clk) emulationMode <= 1'b0;
      wr(RB + sram_pkg::OFF_CONFIG, sram_pkg::SIZE_WORD, 16'h0100, 1);
      rd(ARR, 0, 0, 0, 16'h0000);
      rd(ARR, 1, 0, 1, mem[0]);
      // sync reset on the take edge: the write under way must still land
      d = 16'($urandom);
      fork
         wr(ARR + 24'h2, sram_pkg::SIZE_WORD, d, 1);
         begin
            @(posedge sys_clk) syncReset <= 1'b1;
            @(posedge sys_clk) syncReset <= 1'b0;
         end
      join
      mem[1] = d;
      wr(RB + sram_pkg::OFF_CONFIG, sram_pkg::SIZE_WORD, 16'h0100, 1);
      wr(RB + sram_pkg::OFF_BASE, sram_pkg::SIZE_WORD, BV, 1);
      rd(ARR + 24'h2, 1, 0, 1, mem[1]);
      wr(RB + sram_pkg::OFF_CONFIG, sram_pkg::SIZE_WORD, 16'h8100, 1);
      rd(ARR, 1, 0, 0, 16'h0000);
      @(posedge sys_clk) moduleMapSelect <= 1'b1;
      rd(RH + sram_pkg::OFF_CONFIG, 1, 0, 1, 16'h8100);
      rd(RB + sram_pkg::OFF_CONFIG, 1, 0, 0, 16'h0000);
      @(posedge sys_clk) syncReset <= 1'b1;
      rd(ARR, 1, 0, 0, 16'h0000);
      syncReset <= 1'b0;
      rd(RH + sram_pkg::OFF_BASE, 1, 0, 1, 16'h0001);
      wr(RH + sram_pkg::OFF_BASE + 24'h1, sram_pkg::SIZE_BYTE, 16'h0008, 1);
      wr(RH + sram_pkg::OFF_BASE, sram_pkg::SIZE_WORD, BV, 1);
      rd(RH + sram_pkg::OFF_BASE, 1, 0, 1, 16'h0008);
      @(posedge sys_clk) testMode <= 1'b1;
      wr(RH + sram_pkg::OFF_TEST, sram_pkg::SIZE_WORD, 16'h0001, 1);
      wr(RH + sram_pkg::OFF_BASE, sram_pkg::SIZE_WORD, BV, 1);
      rd(RH + sram_pkg::OFF_BASE, 1, 0, 1, BV);
      @(posedge sys_clk) syncReset <= 1'b1;
      @(posedge sys_clk) syncReset <= 1'b0;
      wr(RH + sram_pkg::OFF_BASE, sram_pkg::SIZE_WORD, {RH[23:11], 3'h0}, 1);
      rd(RH + sram_pkg::OFF_BASE, 1, 0, 1, {RH[23:11], 3'h1});
      tally_and_finish();
   end
endmodule
bind sr_controller sr_checker chk (.*);
